// ---- rtl/loop_pattern_detect.sv ----
// Detects seven consecutive ones and the flag pattern on the received stream
`timescale 1ns/100ps
module loop_pattern_detect
(
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic bitStrobe,
   input  wire logic bitIn,
   output logic      sevenOnes,
   output logic      flagMatch
);
   import loop_pkg::*;

   logic [7:0] history;
   logic [2:0] onesRun;

   // ----------------------------------------------------------------
   // Bit history and run of ones
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         history <= 8'h00;
         onesRun <= COUNT_ZERO;
      end
      else if (bitStrobe)
      begin
         history <= {bitIn, history[7:1]};
         if (!bitIn)
            onesRun <= COUNT_ZERO;
         else if (onesRun != ONES_EOP)
            onesRun <= onesRun + COUNT_ONE;   // Saturates at seven
      end
   end

   // One-cycle event pulses, a cycle after the strobe
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sevenOnes <= 1'b0;
         flagMatch <= 1'b0;
      end
      else
      begin
         sevenOnes <= bitStrobe && bitIn && (onesRun == ONES_EOP - COUNT_ONE);
         flagMatch <= bitStrobe && ({bitIn, history[7:1]} == FLAG_PATTERN);
      end
   end

   // A flag never coincides with the seventh one
   pattern_excl_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      flagMatch |-> !sevenOnes) else $error("flag and seven ones together");

endmodule

// ---- rtl/loop_pkg.sv ----
// Shared constants and types for the loop-mode secondary station
package loop_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int         ADDR_W        = 5;
   localparam logic [4:0] MISC_CTRL_OFS = 5'h00;   // misc_txrx_control_reg
   localparam logic [4:0] MISC_STAT_OFS = 5'h04;   // misc_status_reg
   localparam logic [4:0] PRIM_STAT_OFS = 5'h08;   // primary_status_reg
   localparam logic [4:0] TX_DATA_OFS   = 5'h0C;   // Transmit holding byte
   localparam logic [4:0] TX_PARAM_OFS  = 5'h10;   // tx_param_reg

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_IRQ_EN_BIT   = 0;
   localparam int CTRL_LOOP_BIT     = 1;
   localparam int CTRL_ABORT_UR_BIT = 2;
   localparam int CTRL_IDLE_BIT     = 3;
   localparam int CTRL_GAOP_BIT     = 4;
   localparam int CTRL_ENC_LSB      = 5;
   localparam int CTRL_CRC_BIT      = 7;
   localparam int STAT_ONLOOP_BIT   = 1;
   localparam int STAT_SENDING_BIT  = 4;
   localparam int PRIM_EMPTY_BIT    = 2;
   localparam int PRIM_HUNT_BIT     = 4;
   localparam int PRIM_BREAK_BIT    = 7;
   localparam int TXD_LAST_BIT      = 8;
   localparam int TXP_ENABLE_BIT    = 3;

   // ----------------------------------------------------------------
   // Reset values, encodings, line patterns
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic        TXEN_RESET   = 1'b0;
   localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
   localparam logic [1:0]  ENC_NRZ      = 2'b00;
   localparam logic [1:0]  ENC_NRZI     = 2'b01;
   localparam logic [7:0]  FLAG_PATTERN = 8'h7E;
   localparam logic [2:0]  ONES_EOP     = 3'h7;
   localparam logic [2:0]  STUFF_LIMIT  = 3'h5;
   localparam logic [2:0]  BIT_LAST     = 3'h7;
   localparam logic [2:0]  COUNT_ZERO   = 3'h0;
   localparam logic [2:0]  COUNT_ONE    = 3'h1;

   // Line states of the station
   typedef enum logic [2:0]
   {
      OFF_LOOP  = 3'b000,   // Not in loop mode, line marks
      DIRECT    = 3'b001,   // Output tied to input, no bit delay
      REPEAT    = 3'b010,   // On loop, one-bit delay in path
      CONVERT   = 3'b011,   // Turning the poll into a flag
      SEND_FLAG = 3'b100,   // Sending a flag
      SEND_DATA = 3'b101,   // Sending a data byte
      POL_FIX   = 3'b110    // Extra zero to match polarity
   } loop_state_t;

endpackage

// ---- rtl/sdlc_loop_secondary_station.sv ----
// Loop-mode secondary station: loop entry, poll conversion, sending and exit
`timescale 1ns/100ps
// Notes on behaviour
// - Deselecting loop keeps delay until next poll, unless already hunting after one
// - Exit finishes current message, then disconnects
// - Exit write also sets underrun and idle
// - On-loop status clears when leaving loop
// - NRZI: extra zero restores matching line polarity
// - NRZI allowed, chosen by encoding field
// - Loop mode ties output to input directly
// - Seven ones: break, delay, on-loop, hunt
// - Send only after flag then another poll
// - Poll-go turns next poll into a flag
// - Poll sets break and hunt; a converted poll also sets loop-sending
// - One flag if data ready, else flags
// - Single frame closes with one flag, stops sending
// - Poll-go still set: flags until more data
// - Underrun and idle selections ignored in loop
// - Orderly exit on seven ones, clears on-loop
// - Loop and poll-go bits one and four
// - Poll detection raises status interrupt if enabled
module sdlc_loop_secondary_station
(
   input  wire logic                          ref_clk,
   input  wire logic                          arst_n,
   input  wire logic [loop_pkg::ADDR_W-1:0]   address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [31:0]                   writedata,
   output logic      [31:0]                   readdata,
   output logic                               waitrequest,
   input  wire logic                          rxLine,
   input  wire logic                          rxBitStrobe,
   output logic                               txLine,
   output logic                               extStatusIrq
);
   import loop_pkg::*;

   loop_state_t state;
   logic [7:0]  miscCtrl;
   logic        txEnable;
   logic        onLoop;
   logic        loopSending;
   logic        hunt;
   logic        breakAbort;
   logic        flagSinceEop;
   logic        rxDelay;
   logic [7:0]  txShift;
   logic [2:0]  txCnt;
   logic [2:0]  onesRun;
   logic [7:0]  holdByte;
   logic        holdValid;
   logic        holdLast;
   logic        curLast;
   logic        sevenOnes;
   logic        flagMatch;

   logic        loopMode;
   logic        goActive;
   logic        nrziSel;
   logic        rxBit;
   logic        accept;
   logic        commit;
   logic        goOnEvt;
   logic        convertEvt;
   logic        exitEvt;
   logic        txBit;
   logic        encLevel;
   logic        lastFlagBit;
   logic        lastDataBit;
   logic        takeHold;
   logic        finishEvt;
   logic        breakClear;

   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   // Loop and poll-go bits; underrun and idle bits are stored only
   assign loopMode = miscCtrl[CTRL_LOOP_BIT];
   assign goActive = miscCtrl[CTRL_GAOP_BIT];
   assign nrziSel  = miscCtrl[CTRL_ENC_LSB +: 2] == ENC_NRZI;
   // Receive decoding; the delay flop holds the previous line level
   assign rxBit    = nrziSel ? (rxLine == rxDelay) : rxLine;

   // ----------------------------------------------------------------
   // Receive pattern detection
   // ----------------------------------------------------------------
   loop_pattern_detect u_detect
   (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .bitStrobe (rxBitStrobe),
      .bitIn     (rxBit),
      .sevenOnes (sevenOnes),
      .flagMatch (flagMatch)
   );

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // Accept when idle; a data write waits while the holding byte is full
   assign accept = (read || write) && waitrequest
                   && !(write && address == TX_DATA_OFS && holdValid);
   assign commit = write && !waitrequest;
   assign breakClear = commit && address == PRIM_STAT_OFS && writedata[PRIM_BREAK_BIT];

   // Waitrequest low for exactly one cycle per access
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         waitrequest <= 1'b1;
      else
         waitrequest <= !accept;
   end

   // Read data captured when the access is accepted
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         readdata <= READ_ZERO;
      else if (accept && read)
      begin
         readdata <= READ_ZERO;
         case (address)
            MISC_CTRL_OFS: readdata[7:0] <= miscCtrl;
            MISC_STAT_OFS:
            begin
               readdata[STAT_ONLOOP_BIT]  <= onLoop;
               readdata[STAT_SENDING_BIT] <= loopSending;
            end
            PRIM_STAT_OFS:
            begin
               readdata[PRIM_EMPTY_BIT] <= !holdValid;
               readdata[PRIM_HUNT_BIT]  <= hunt;
               readdata[PRIM_BREAK_BIT] <= breakAbort;
            end
            TX_PARAM_OFS:  readdata[TXP_ENABLE_BIT] <= txEnable;
            default:       readdata <= READ_ZERO;
         endcase
      end
   end

   // Control registers, written at the completing edge
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         miscCtrl <= CTRL_RESET;
         txEnable <= TXEN_RESET;
      end
      else if (commit)
      begin
         if (address == MISC_CTRL_OFS)
            miscCtrl <= writedata[7:0];
         if (address == TX_PARAM_OFS)
            txEnable <= writedata[TXP_ENABLE_BIT];
      end
   end

   // Transmit holding byte; set by the bus, emptied by the shifter
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         holdByte  <= 8'h00;
         holdValid <= 1'b0;
         holdLast  <= 1'b0;
      end
      else if (commit && address == TX_DATA_OFS)
      begin
         holdByte  <= writedata[7:0];
         holdValid <= 1'b1;
         holdLast  <= writedata[TXD_LAST_BIT];
      end
      else if (takeHold)
         holdValid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Loop events
   // ----------------------------------------------------------------
   // Going on loop needs poll-go and seven ones
   assign goOnEvt    = state == DIRECT && loopMode && goActive && sevenOnes;
   // Poll conversion only after a flag since the last poll
   assign convertEvt = state == REPEAT && sevenOnes && flagSinceEop
                       && goActive && txEnable && loopMode;
   // Exit waits for the next poll unless already hunting after one
   assign exitEvt    = state == REPEAT && !loopMode && (hunt || sevenOnes);

   // ----------------------------------------------------------------
   // Transmit bit selection
   // ----------------------------------------------------------------
   always_comb
   begin
      case (state)
         SEND_FLAG: txBit = txShift[0];
         SEND_DATA: txBit = (onesRun == STUFF_LIMIT) ? 1'b0 : txShift[0];
         default:   txBit = 1'b0;   // Converted poll bit and polarity zero
      endcase
   end

   // NRZI sends a zero as a transition
   assign encLevel    = nrziSel ? (txBit ? txLine : !txLine) : txBit;
   assign lastFlagBit = state == SEND_FLAG && rxBitStrobe && txCnt == BIT_LAST;
   assign lastDataBit = state == SEND_DATA && rxBitStrobe && txCnt == BIT_LAST
                        && onesRun != STUFF_LIMIT;
   // Next byte follows a flag, or a byte not marked last
   assign takeHold    = holdValid && (lastFlagBit || (lastDataBit && !curLast));
   // Nothing left and poll-go clear: the closing flag is done
   assign finishEvt   = lastFlagBit && !holdValid && !goActive;

   // ----------------------------------------------------------------
   // Line state machine and transmit shifter
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state   <= OFF_LOOP;
         txShift <= 8'h00;
         txCnt   <= COUNT_ZERO;
         onesRun <= COUNT_ZERO;
         curLast <= 1'b0;
      end
      else
      begin
         case (state)
            OFF_LOOP:
               if (loopMode)
               begin
                  state   <= DIRECT;
                  txShift <= FLAG_PATTERN;   // Flag ready at shifter end
                  txCnt   <= COUNT_ZERO;
               end
            DIRECT:
               if (!loopMode)
                  state <= OFF_LOOP;
               else if (goOnEvt)
                  state <= REPEAT;
            REPEAT:
               if (exitEvt)
                  state <= OFF_LOOP;
               else if (convertEvt)
                  state <= CONVERT;
            CONVERT:
               if (rxBitStrobe)
               begin
                  state   <= SEND_FLAG;
                  txShift <= FLAG_PATTERN;
                  txCnt   <= COUNT_ZERO;
               end
            SEND_FLAG:
               if (rxBitStrobe)
               begin
                  txShift <= {1'b0, txShift[7:1]};
                  txCnt   <= txCnt + COUNT_ONE;
                  if (txCnt == BIT_LAST)
                  begin
                     onesRun <= COUNT_ZERO;
                     if (holdValid)
                     begin
                        state   <= SEND_DATA;
                        txShift <= holdByte;
                        curLast <= holdLast;
                     end
                     else if (goActive)
                        txShift <= FLAG_PATTERN;
                     else if (nrziSel && encLevel != rxDelay)
                        state <= POL_FIX;
                     else
                        state <= REPEAT;
                  end
               end
            SEND_DATA:
               if (rxBitStrobe)
               begin
                  if (onesRun == STUFF_LIMIT)
                     onesRun <= COUNT_ZERO;   // Stuffed zero, byte waits
                  else
                  begin
                     onesRun <= txShift[0] ? onesRun + COUNT_ONE : COUNT_ZERO;
                     txShift <= {1'b0, txShift[7:1]};
                     txCnt   <= txCnt + COUNT_ONE;
                     if (txCnt == BIT_LAST)
                     begin
                        // Underrun sends flags, never an abort
                        if (holdValid && !curLast)
                        begin
                           txShift <= holdByte;
                           curLast <= holdLast;
                        end
                        else
                        begin
                           state   <= SEND_FLAG;
                           txShift <= FLAG_PATTERN;
                        end
                     end
                  end
               end
            POL_FIX:
               if (rxBitStrobe)
                  state <= REPEAT;
            default:
               state <= OFF_LOOP;
         endcase
      end
   end

   // Repeat delay, one bit time
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rxDelay <= 1'b1;
      else if (rxBitStrobe)
         rxDelay <= rxLine;
   end

   // Serial output per line state
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         txLine <= 1'b1;
      else
      begin
         case (state)
            OFF_LOOP: txLine <= 1'b1;     // Marks regardless of idle bit
            DIRECT:   txLine <= rxLine;
            REPEAT:
               if (rxBitStrobe)
                  txLine <= rxDelay;
            default:
               if (rxBitStrobe)
                  txLine <= encLevel;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   // On-loop status
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         onLoop <= 1'b0;
      else if (goOnEvt)
         onLoop <= 1'b1;
      else if (exitEvt)
         onLoop <= 1'b0;
   end

   // Loop-sending status
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         loopSending <= 1'b0;
      else if (convertEvt)
         loopSending <= 1'b1;
      else if (finishEvt)
         loopSending <= 1'b0;
   end

   // Hunt: set on seven ones while on loop, left on a flag
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         hunt <= 1'b0;
      else if (goOnEvt || (onLoop && sevenOnes))
         hunt <= 1'b1;
      else if (flagMatch)
         hunt <= 1'b0;
   end

   // Break/abort/poll, sticky; write one clears, a new event wins
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         breakAbort <= 1'b0;
      else if (goOnEvt || (onLoop && sevenOnes))
         breakAbort <= 1'b1;
      else if (breakClear)
         breakAbort <= 1'b0;
   end

   // Flag seen since the last poll qualifies the next poll
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         flagSinceEop <= 1'b0;
      else if (sevenOnes)
         flagSinceEop <= 1'b0;
      else if (onLoop && flagMatch)
         flagSinceEop <= 1'b1;
   end

   // Status interrupt gated by its enable
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         extStatusIrq <= 1'b0;
      else
         extStatusIrq <= breakAbort && miscCtrl[CTRL_IRQ_EN_BIT];
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence goOnCause;
      state == DIRECT && loopMode && goActive && sevenOnes;
   endsequence

   sequence onLoopResult;
      onLoop && hunt && breakAbort && state == REPEAT;
   endsequence

   go_on_loop_a: assert property (goOnCause |=> onLoopResult)
      else $error("going on loop did not set status and delay");

   direct_path_a: assert property (state == DIRECT && $past(state) == DIRECT
      |-> txLine == $past(rxLine)) else $error("direct path not following input");

   repeat_delay_a: assert property (state == REPEAT && rxBitStrobe && !exitEvt
      |=> txLine == $past(rxDelay)) else $error("repeat path not one bit late");

   no_early_send_a: assert property (state == REPEAT && sevenOnes && !flagSinceEop
      |=> state != CONVERT) else $error("sent without flag and poll");

   convert_zero_a: assert property (state == CONVERT && rxBitStrobe && !nrziSel
      |=> !txLine && state == SEND_FLAG) else $error("poll not turned into a flag");

   sending_flag_a: assert property (convertEvt |=> loopSending ##0 breakAbort)
      else $error("poll did not raise sending and break");

   leave_clears_a: assert property ($fell(onLoop) |-> state == OFF_LOOP
      && $past(state) == REPEAT && !loopMode) else $error("on-loop cleared badly");

   close_done_a: assert property (finishEvt |=> !loopSending
      && (state == REPEAT || state == POL_FIX)) else $error("frame close wrong");

   pol_fix_a: assert property (state == POL_FIX && rxBitStrobe
      |=> txLine != $past(txLine) && txLine == $past(rxDelay))
      else $error("polarity zero did not match line");

   bus_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

endmodule

// ---- tb/ring_primary_model.sv ----
// Ring line source standing in for the loop primary and upstream stations
`timescale 1ns/100ps
module ring_primary_model
(
   input  wire logic ref_clk,
   input  wire logic arst_n,
   output logic      rxBitStrobe,
   output logic      rxLine
);
   logic [1:0] div;
   logic       bits[$];
   // Bit strobe every four clocks; marking line when idle
   always @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
      begin
         div <= 2'h0;
         rxBitStrobe <= 1'b0;
         rxLine <= 1'b1;
      end
      else
      begin
         div <= div + 2'h1;
         rxBitStrobe <= (div == 2'h3);
         if (div == 2'h3)
            rxLine <= (bits.size() > 0) ? bits.pop_front() : 1'b1;
      end
   // Queue a byte LSB first and wait until it has left
   // Bits are queued between edges so the popping edge never races the push
   task automatic sendByte(input logic [7:0] b);
      @(negedge ref_clk);
      for (int i = 0; i < 8; i++)
         bits.push_back(b[i]);
      wait (bits.size() == 0);
      repeat (8) @(posedge ref_clk);
   endtask
endmodule

// ---- tb/tb_sdlc_loop_secondary_station.sv ----
// Bench for the loop-mode secondary station
`timescale 1ns/100ps
module tb_sdlc_loop_secondary_station;
   import loop_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
   logic [4:0]  address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata, s = 32'd85812, rnd;
   logic waitrequest, rxLine, rxBitStrobe, txLine, extStatusIrq, r;
   logic [63:0] notes[$];
   int n_errors = 0, cmp_count = 0;
   sdlc_loop_secondary_station dut (.ref_clk(ref_clk), .arst_n(arst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .rxLine(rxLine), .rxBitStrobe(rxBitStrobe),
      .txLine(txLine), .extStatusIrq(extStatusIrq));
   ring_primary_model ring (.ref_clk(ref_clk), .arst_n(arst_n),
      .rxBitStrobe(rxBitStrobe), .rxLine(rxLine));
   initial forever #25 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One Avalon access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      write <= w;
      read <= !w;
      address <= a;
      writedata <= d;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      notes.push_back({m, e});
      acc(1'b0, a, 32'h0);
   endtask
   // Read results compared in the cycle they are taken
   always @(posedge ref_clk)
      if (read && waitrequest === 1'b0 && notes.size() > 0)
      begin
         logic [63:0] n;
         n = notes.pop_front();
         chk(readdata & n[63:32], n[31:0]);
      end
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end
   initial
   begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(MISC_CTRL_OFS, 32'hFF, 32'h0);
      rd(5'h14, 32'hFFFFFFFF, 32'h0);
      acc(1'b1, MISC_CTRL_OFS, 32'h88);
      rd(MISC_CTRL_OFS, 32'hFF, 32'h88);
      acc(1'b1, MISC_CTRL_OFS, 32'h02);
      rd(MISC_CTRL_OFS, 32'hFF, 32'h02);
      fork ring.sendByte(8'h5A); join_none
      // Output follows input with no bit delay
      repeat (12)
      begin
         @(posedge ref_clk);
         r = rxLine;
         @(posedge ref_clk);
         chk(txLine, r);
      end
      acc(1'b1, TX_PARAM_OFS, 32'h08);
      acc(1'b1, MISC_CTRL_OFS, 32'h13);
      ring.sendByte(8'hFF);
      rd(MISC_STAT_OFS, 32'h12, 32'h02);
      rd(PRIM_STAT_OFS, 32'h90, 32'h90);
      chk(extStatusIrq, 1'b1);
      acc(1'b1, MISC_CTRL_OFS, 32'h03);
      acc(1'b1, PRIM_STAT_OFS, 32'h80);
      ring.sendByte(FLAG_PATTERN);
      rd(MISC_STAT_OFS, 32'h10, 32'h0);
      rd(PRIM_STAT_OFS, 32'h90, 32'h0);
      // Poll-go again before the poll that follows the flag
      acc(1'b1, MISC_CTRL_OFS, 32'h13);
      ring.sendByte(8'hFF);
      rd(MISC_STAT_OFS, 32'h12, 32'h12);
      rd(PRIM_STAT_OFS, 32'h90, 32'h90);
      rnd = xs();
      acc(1'b1, TX_DATA_OFS, {24'h0, rnd[7:0]});
      acc(1'b1, MISC_CTRL_OFS, 32'h03);
      acc(1'b1, TX_DATA_OFS, {23'h0, 1'b1, rnd[15:8]});
      repeat (400) @(posedge ref_clk);
      rd(MISC_STAT_OFS, 32'h12, 32'h02);
      rd(PRIM_STAT_OFS, 32'h04, 32'h04);
      acc(1'b1, MISC_CTRL_OFS, 32'h0C);
      ring.sendByte(8'hFF);
      rd(MISC_STAT_OFS, 32'h12, 32'h0);
      chk(txLine, 1'b1);
      repeat (4) @(posedge ref_clk);
      test_done();
   end
endmodule
